// >>> ahs_regs.vh
/*
  Register offsets, field positions, reset values and mode codes of the axis
  homing sequencer. Definitions only; included by every design file that
  needs them. Assumes an 8-bit APB byte address and 32-bit data.
*/
`ifndef AHS_REGS_VH
`define AHS_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AHS_OFF_CTRL      8'h00
`define AHS_OFF_STATUS    8'h04
`define AHS_OFF_HOME_POS  8'h08
`define AHS_OFF_AXIS_POS  8'h0c

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define AHS_CTRL_MODE_LSB 0
`define AHS_CTRL_MODE_MSB 5
`define AHS_CTRL_START    8
`define AHS_CTRL_RST      6'h0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define AHS_ST_BUSY       0
`define AHS_ST_DONE       1
`define AHS_ST_RSVD       2
`define AHS_ST_DIR        3
`define AHS_ST_SPEED      4
`define AHS_ST_MOVE       5
`define AHS_ST_STEP_LSB   8
`define AHS_ST_PIN_LSB    16

// ----------------------------------------------------------------------
// Homing mode codes
// ----------------------------------------------------------------------
`define AHS_MODE_26       6'h1a
`define AHS_MODE_27       6'h1b
`define AHS_MODE_28       6'h1c
`define AHS_MODE_29       6'h1d
`define AHS_MODE_30       6'h1e
`define AHS_MODE_31       6'h1f
`define AHS_MODE_32       6'h20
`define AHS_MODE_33       6'h21
`define AHS_MODE_34       6'h22
`define AHS_MODE_35       6'h23

// ----------------------------------------------------------------------
// Motion encodings
// ----------------------------------------------------------------------
`define AHS_DIR_POS       1'b1
`define AHS_DIR_NEG       1'b0
`define AHS_SPD_FIRST     1'b0
`define AHS_SPD_SECOND    1'b1

`endif

// >>> ahs_sync.v
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels and only dout is read by logic.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_b,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  // The first stage feeds the second stage only, to contain metastability.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule // ahs_sync

`default_nettype wire

// >>> ahs_edge.v
/*
  Rise and fall detector for a group of synchronised levels.
  Assumes the inputs are already in the sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_edge #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_b,
  input  wire [W-1:0] lvl,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] prev_reg;

  // ----------------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------------
  // Resets low, so a level already high out of reset reads as one rise.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= {W{1'b0}};
    end else begin
      prev_reg <= lvl;
    end
  end

  assign rise = lvl & ~prev_reg;
  assign fall = ~lvl & prev_reg;

endmodule // ahs_edge

`default_nettype wire

// >>> ahs_homing.v
/*
  Homing sequencer for one servo axis, with its APB register slave.
  Holds the mode register, the sequencing state machine, the home latch and
  the motion command outputs. Assumes an APB master on sys_clk, a position
  counter on sys_clk driving axis_pos, and asynchronous switch and index pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ahs_regs.vh"

module ahs_homing (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        home_sw,
  input  wire        limit_pos,
  input  wire        limit_neg,
  input  wire        index_pulse,
  input  wire [31:0] axis_pos,
  output wire        move_en,
  output wire        move_dir_pos,
  output wire        speed_second,
  output wire        home_done,
  output wire [31:0] home_pos
);

  // ----------------------------------------------------------------------
  // States and steps
  // ----------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_SEEK  = 2'b01;
  localparam [1:0] ST_DONE  = 2'b10;
  localparam [1:0] ST_FAULT = 2'b11;

  localparam [1:0] SP_A = 2'b00;
  localparam [1:0] SP_B = 2'b01;
  localparam [1:0] SP_C = 2'b10;
  localparam [1:0] SP_D = 2'b11;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wire [3:0]  pins_sync;
  wire [3:0]  pins_rise;
  wire [3:0]  pins_fall;
  wire        hs;
  wire        hs_on;
  wire        hs_off;
  wire        lim_p;
  wire        lim_n;
  wire        idx_hit;
  wire        setup_ph;
  wire        access_ph;
  wire        addr_ok;
  wire [31:0] status_word;

  reg  [5:0]  mode_reg;
  reg         cmd_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [1:0]  step_reg;
  reg  [1:0]  step_next;
  reg         dir_reg;
  reg         dir_next;
  reg         spd_reg;
  reg         spd_next;
  reg         latch_now;
  reg         move_reg;
  reg         done_reg;
  reg  [31:0] home_pos_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;

  // ----------------------------------------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------------------------------------
  // Order of the group: index, negative limit, positive limit, home switch.
  ahs_sync #(
    .W (4)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({index_pulse, limit_neg, limit_pos, home_sw}),
    .dout    (pins_sync)
  );

  ahs_edge #(
    .W (4)
  ) u_edge (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .lvl     (pins_sync),
    .rise    (pins_rise),
    .fall    (pins_fall)
  );

  assign hs      = pins_sync[0];
  assign hs_on   = pins_rise[0];
  assign hs_off  = pins_fall[0];
  assign lim_p   = pins_sync[1];
  assign lim_n   = pins_sync[2];
  assign idx_hit = pins_rise[3];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // No wait states: read data is captured in the setup cycle.
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign addr_ok   = (paddr == `AHS_OFF_CTRL) | (paddr == `AHS_OFF_STATUS) |
                     (paddr == `AHS_OFF_HOME_POS) | (paddr == `AHS_OFF_AXIS_POS);
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~addr_ok;
  assign prdata    = rdata_reg;

  assign status_word = {12'h000, pins_sync, 6'h0, step_reg, 2'b00, move_reg,
                        spd_reg, dir_reg, (state_reg == ST_FAULT), done_reg,
                        (state_reg == ST_SEEK)};

  // Read multiplexer; unmapped addresses read zero and flag an error.
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `AHS_OFF_CTRL:     rdata_next = {26'h0, mode_reg};
      `AHS_OFF_STATUS:   rdata_next = status_word;
      `AHS_OFF_HOME_POS: rdata_next = home_pos_reg;
      `AHS_OFF_AXIS_POS: rdata_next = axis_pos;
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Control register and homing command
  // ----------------------------------------------------------------------
  // The start bit is a write-one pulse; it acts on the next edge with the
  // mode written in the same transfer, so mode and start may go together.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `AHS_CTRL_RST;
      cmd_reg  <= 1'b0;
    end else begin
      cmd_reg <= 1'b0;
      if (access_ph & pwrite & (paddr == `AHS_OFF_CTRL)) begin
        mode_reg <= pwdata[`AHS_CTRL_MODE_MSB:`AHS_CTRL_MODE_LSB];
        cmd_reg  <= pwdata[`AHS_CTRL_START];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  // A new command always restarts the search, even mid-sequence, except that
  // mode 35 latches at once, and codes other than 26 to 30, 33 and 34 fault.
  // Limit switches are acted on only in step A; elsewhere the axis is past them.
  always @* begin
    state_next = state_reg;
    step_next  = step_reg;
    dir_next   = dir_reg;
    spd_next   = spd_reg;
    latch_now  = 1'b0;
    if (cmd_reg) begin
      state_next = ST_SEEK;
      step_next  = SP_A;
      spd_next   = `AHS_SPD_FIRST;
      dir_next   = `AHS_DIR_NEG;
      case (mode_reg)
        `AHS_MODE_26, `AHS_MODE_27: begin
          if (hs) begin
            dir_next  = `AHS_DIR_POS;
            spd_next  = `AHS_SPD_SECOND;
            step_next = SP_B;
          end else begin
            dir_next = (mode_reg == `AHS_MODE_26) ? `AHS_DIR_POS
                                                  : `AHS_DIR_NEG;
          end
        end
        `AHS_MODE_28: begin
          if (hs) begin
            dir_next  = `AHS_DIR_POS;
            spd_next  = `AHS_SPD_SECOND;
            step_next = SP_D;
          end
        end
        `AHS_MODE_29: begin
          if (hs) begin
            spd_next  = `AHS_SPD_SECOND;
            step_next = SP_D;
          end
        end
        `AHS_MODE_30: begin
          if (hs) begin
            spd_next  = `AHS_SPD_SECOND;
            step_next = SP_B;
          end
        end
        `AHS_MODE_33: begin
          spd_next = `AHS_SPD_SECOND;
        end
        `AHS_MODE_34: begin
          dir_next = `AHS_DIR_POS;
          spd_next = `AHS_SPD_SECOND;
        end
        `AHS_MODE_35: begin
          state_next = ST_DONE;
          latch_now  = 1'b1;
        end
        default: begin
          state_next = ST_FAULT;
        end
      endcase
    end else if (state_reg == ST_SEEK) begin
      case (mode_reg)
        `AHS_MODE_26, `AHS_MODE_27, `AHS_MODE_30: begin
          case (step_reg)
            SP_A: begin
              if (hs_on) begin
                spd_next  = `AHS_SPD_SECOND;
                step_next = SP_B;
                if (mode_reg == `AHS_MODE_27) begin
                  dir_next = ~dir_reg;
                end
              end else if (!hs && ((mode_reg == `AHS_MODE_26) ? lim_p : lim_n)) begin
                dir_next  = ~dir_reg;
                step_next = SP_C;
              end
            end
            SP_C: begin
              if (hs_on) begin
                spd_next  = `AHS_SPD_SECOND;
                step_next = SP_B;
                if (mode_reg != `AHS_MODE_27) begin
                  dir_next = ~dir_reg;
                end
              end
            end
            default: begin
              if (hs_off) begin
                state_next = ST_DONE;
                latch_now  = 1'b1;
              end
            end
          endcase
        end
        `AHS_MODE_28, `AHS_MODE_29: begin
          case (step_reg)
            SP_A: begin
              if (hs_on) begin
                if (mode_reg == `AHS_MODE_28) begin
                  state_next = ST_DONE;
                  latch_now  = 1'b1;
                end else begin
                  spd_next  = `AHS_SPD_SECOND;
                  step_next = SP_D;
                end
              end else if (!hs && lim_n) begin
                dir_next  = ~dir_reg;
                step_next = (mode_reg == `AHS_MODE_28) ? SP_C : SP_B;
              end
            end
            SP_C: begin
              if (hs_on) begin
                step_next = SP_D;
              end
            end
            SP_D: begin
              if (hs_off) begin
                dir_next  = ~dir_reg;
                step_next = SP_B;
              end
            end
            default: begin
              if (hs_on) begin
                state_next = ST_DONE;
                latch_now  = 1'b1;
              end
            end
          endcase
        end
        `AHS_MODE_33, `AHS_MODE_34: begin
          if (idx_hit) begin
            state_next = ST_DONE;
            latch_now  = 1'b1;
          end
        end
        default: begin
          state_next = ST_FAULT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer registers and home latch
  // ----------------------------------------------------------------------
  // Motion is commanded only while seeking; the done flag holds until the
  // next command clears it; a command for mode 35 keeps it set.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      step_reg     <= SP_A;
      dir_reg      <= `AHS_DIR_NEG;
      spd_reg      <= `AHS_SPD_FIRST;
      move_reg     <= 1'b0;
      done_reg     <= 1'b0;
      home_pos_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      dir_reg   <= dir_next;
      spd_reg   <= spd_next;
      move_reg  <= (state_next == ST_SEEK);
      done_reg  <= (state_next == ST_DONE);
      if (latch_now) begin
        home_pos_reg <= axis_pos;
      end
    end
  end

  assign move_en      = move_reg;
  assign move_dir_pos = dir_reg;
  assign speed_second = spd_reg;
  assign home_done    = done_reg;
  assign home_pos     = home_pos_reg;

endmodule // ahs_homing

`default_nettype wire

// >>> ahs_homing_chk.sv
/*
  Checker for the axis homing sequencer, bound to ahs_homing.
  Assumes it sees only the top module ports on the single sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_homing_chk (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        home_sw,
  input wire logic        limit_pos,
  input wire logic        limit_neg,
  input wire logic        index_pulse,
  input wire logic [31:0] axis_pos,
  input wire logic        move_en,
  input wire logic        move_dir_pos,
  input wire logic        speed_second,
  input wire logic        home_done,
  input wire logic [31:0] home_pos
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic [5:0] mode_w;
  logic [5:0] mode_d;
  wire        cmd = psel && penable && pwrite && (paddr == 8'h00) && pwdata[8];

  // The sequencer adopts a new mode one edge after the command write.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_w <= 6'h0;
      mode_d <= 6'h0;
    end else begin
      if (cmd)
        mode_w <= pwdata[5:0];
      mode_d <= mode_w;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  done_hold_a:
    assert property (home_done && !cmd && !$past(cmd) |=> home_done) else $error("home_done fell with no command");
  stop_done_a:
    assert property (home_done |-> !move_en) else $error("motion while home_done");
  capture_a:
    assert property ($rose(home_done) |-> home_pos == $past(axis_pos)) else $error("home_pos not captured");
  pos_hold_a:
    assert property (home_done && $past(home_done) && !$past(cmd) && !$past(cmd, 2) |-> $stable(home_pos))
      else $error("home_pos changed while done");
  seek_start_a:
    assert property (cmd && pwdata[5:0] >= 6'h1a && pwdata[5:0] <= 6'h1e |=> ##1 move_en && !home_done)
      else $error("switch mode did not start motion");
  first_pos_a:
    assert property (cmd && pwdata[5:0] == 6'h1a && !home_sw && !$past(home_sw, 4)
      |=> ##1 move_en && move_dir_pos && !speed_second) else $error("wrong start motion");
  seek_neg_a:
    assert property (cmd && pwdata[5:0] == 6'h21 |=> ##1 move_en && !move_dir_pos && speed_second)
      else $error("index mode negative start wrong");
  seek_pos_a:
    assert property (cmd && pwdata[5:0] == 6'h22 |=> ##1 move_en && move_dir_pos && speed_second)
      else $error("index mode positive start wrong");
  at_once_a:
    assert property (cmd && pwdata[5:0] == 6'h23 |=> ##1 home_done && !move_en)
      else $error("current position home late");
  reserved_a:
    assert property (cmd && (pwdata[5:0] == 6'h1f || pwdata[5:0] == 6'h20) |=> ##1 (!move_en && !home_done) [*2])
      else $error("reserved mode acted");
  switch_only_a:
    assert property ($rose(home_done) && mode_d >= 6'h1a && mode_d <= 6'h1e |-> home_sw != $past(home_sw, 6))
      else $error("home latched without switch edge");
endmodule // ahs_homing_chk

bind ahs_homing ahs_homing_chk u_chk (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .home_sw, .limit_pos, .limit_neg, .index_pulse, .axis_pos, .move_en, .move_dir_pos,
  .speed_second, .home_done, .home_pos);

`default_nettype wire

// >>> ahs_axis_model.sv
/*
  Behavioural servo axis: position counter, home switch, limits and index.
  Assumes the sequencer drives the move outputs on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_axis_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic [31:0] load_pos,
  input  wire logic        move_en,
  input  wire logic        move_dir_pos,
  input  wire logic        speed_second,
  output wire logic        home_sw,
  output wire logic        limit_pos,
  output wire logic        limit_neg,
  output wire logic        index_pulse,
  output var  logic [31:0] axis_pos
);
  logic [1:0] tick;

  // One step per 4 clocks at first speed, per 2 at second, so the index stays high 4 clocks at first speed and 2 at second.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick     <= 2'h0;
      axis_pos <= 32'h0;
    end else begin
      tick <= tick + 2'h1;
      if (load)
        axis_pos <= load_pos;
      else if (move_en && (speed_second ? tick[0] : tick == 2'h3))
        axis_pos <= move_dir_pos ? axis_pos + 32'h1 : axis_pos - 32'h1;
    end
  end

  // Switch levels follow position; this switch never bounces, unlike a real one.
  assign home_sw     = ($signed(axis_pos) >= 32'sh64) && ($signed(axis_pos) <= 32'shc7);
  assign limit_pos   = $signed(axis_pos) >= 32'sh190;
  assign limit_neg   = $signed(axis_pos) <= -32'sh190;
  assign index_pulse = (axis_pos[5:0] == 6'h0);
endmodule // ahs_axis_model

`default_nettype wire

// >>> ahs_homing_tb_top.sv
/*
  Testbench for the axis homing sequencer: APB tasks and homing cases.
  Assumes ahs_axis_model stands on the pin side and the checker is bound.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_homing_tb_top;
  logic        sys_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        load;
  logic        log_clr;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] load_pos;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic [31:0] axis_pos;
  logic [31:0] home_pos;
  logic        pready;
  logic        pslverr;
  logic        home_sw;
  logic        limit_pos;
  logic        limit_neg;
  logic        index_pulse;
  logic        move_en;
  logic        move_dir_pos;
  logic        speed_second;
  logic        home_done;
  logic [15:0] seq;
  logic [2:0]  prev;
  int          fails;
  int          n_tests;
  int          cyc;

  ahs_homing u_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .home_sw, .limit_pos, .limit_neg, .index_pulse, .axis_pos, .move_en, .move_dir_pos, .speed_second,
    .home_done, .home_pos);
  ahs_axis_model u_axis (.sys_clk, .rst_b, .load, .load_pos, .move_en, .move_dir_pos, .speed_second,
    .home_sw, .limit_pos, .limit_neg, .index_pulse, .axis_pos);

  // ----------------------------------------------------------------------
  // Clock, timeout and motion log
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cycle ceiling; a hung case counts as a mismatch and ends the run.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      complete_run;
    end
  end

  // Each new motion command is logged as a nibble {0, en, dir, speed}.
  // The log has this one driver; a case clears it through log_clr.
  always @(posedge sys_clk) begin
    if (log_clr)
      seq <= 16'h0;
    else if (move_en && {move_en, move_dir_pos, speed_second} != prev)
      seq <= {seq[11:0], 1'b0, move_en, move_dir_pos, speed_second};
    prev <= {move_en, move_dir_pos, speed_second};
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd_o);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Ends once pready is high; only the cycle ceiling bounds this wait.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_o = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Park the axis, start homing, then compare the motion log and the latch window.
  task automatic run_case(input logic [5:0] mode, input logic [31:0] start, input logic [15:0] exp_seq,
                          input logic [31:0] bound);
    int          n;
    logic [31:0] d;
    n = 0;
    load_pos <= start;
    load <= 1'b1;
    log_clr <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    log_clr <= 1'b0;
    repeat (8) @(posedge sys_clk);
    apb_xfer(1'b1, 8'h00, {23'h0, 1'b1, 2'h0, mode}, rd);
    // The done flag of the previous case only clears on the edge at which the
    // start pulse acts, so let it drop before waiting for the new home.
    repeat (2) @(posedge sys_clk);
    while (home_done !== 1'b1 && n < 8000) begin
      @(posedge sys_clk);
      n++;
    end
    d = home_pos - bound + 32'h3;
    chk("home_done", {31'h0, home_done}, 32'h1);
    chk("motion log", {16'h0, seq}, {16'h0, exp_seq});
    chk("home_pos window", {31'h0, d <= 32'h6}, 32'h1);
  endtask

  task automatic complete_run;
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    load = 1'b0;
    load_pos = 32'h0;
    log_clr = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb_xfer(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl reset", rd, 32'h0);
    apb_xfer(1'b0, 8'h08, 32'h0, rd);
    chk("home_pos reset", rd, 32'h0);
    apb_xfer(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped error", {31'h0, err}, 32'h1);
    run_case(6'h1a, 32'h0, 16'h0067, 32'hc8);
    run_case(6'h1a, 32'h96, 16'h0007, 32'hc8);
    run_case(6'h1b, 32'h96, 16'h0007, 32'hc8);
    run_case(6'h1a, 32'hfa, 16'h0647, 32'hc8);
    run_case(6'h1b, 32'hfa, 16'h0047, 32'hc8);
    run_case(6'h1b, 32'h0, 16'h0467, 32'hc8);
    run_case(6'h1c, 32'hfa, 16'h0004, 32'hc7);
    run_case(6'h1c, 32'h96, 16'h0075, 32'hc7);
    run_case(6'h1c, 32'h0, 16'h0464, 32'hc7);
    run_case(6'h1d, 32'hfa, 16'h0457, 32'h64);
    run_case(6'h1d, 32'h96, 16'h0057, 32'h64);
    run_case(6'h1d, 32'h0, 16'h0046, 32'h64);
    run_case(6'h1e, 32'hfa, 16'h0045, 32'h63);
    run_case(6'h1e, 32'h96, 16'h0005, 32'h63);
    run_case(6'h1e, 32'h0, 16'h0465, 32'h63);
    run_case(6'h21, 32'h1e, 16'h0005, 32'h0);
    run_case(6'h22, 32'h1e, 16'h0007, 32'h40);
    run_case(6'h23, 32'h4d, 16'h0000, 32'h4d);
    apb_xfer(1'b0, 8'h08, 32'h0, rd);
    chk("home_pos read", rd, 32'h4d);
    apb_xfer(1'b1, 8'h08, 32'hffffffff, rd);
    apb_xfer(1'b0, 8'h08, 32'h0, rd);
    chk("home_pos read only", rd, 32'h4d);
    // Reserved modes must neither move nor report a home.
    for (int i = 0; i < 2; i++) begin
      apb_xfer(1'b1, 8'h00, {23'h0, 1'b1, 2'h0, 6'h1f + 6'(i)}, rd);
      repeat (4) @(posedge sys_clk);
      apb_xfer(1'b0, 8'h04, 32'h0, rd);
      chk("reserved status", {29'h0, rd[2:0]}, 32'h4);
      chk("reserved motion", {31'h0, move_en}, 32'h0);
    end
    apb_xfer(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl readback", rd, 32'h20);
    apb_xfer(1'b0, 8'h0c, 32'h0, rd);
    chk("axis_pos read", rd, axis_pos);
    complete_run;
  end
endmodule // ahs_homing_tb_top

`default_nettype wire
